//--- hdl/refctl_params.svh
`ifndef REFCTL_PARAMS_SVH
`define REFCTL_PARAMS_SVH

// ------------------------------------------------------------
// Register offsets on the control port
// ------------------------------------------------------------
`define REF_CFG_OFFSET        10'h01c
`define REF_MISC_OFFSET       10'h01d
`define PLL_STATUS_OFFSET     10'h01f

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define REF_CFG_DIFF_BIT      0
`define REF_CFG_FIRST_REFERENCE_INPUT_BIT      1
`define REF_CFG_SECOND_REFERENCE_INPUT_BIT      2
`define REF_MISC_FREEZE_BIT   4
`define REF_MISC_DOUBLER_BIT  5
`define REF_MISC_XTAL_BIT     6
`define REF_MISC_EEPROM_BIT   7

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define REF_CFG_RESET         8'h00
`define REF_MISC_RESET        8'h80
`define PLL_STATUS_RESET      8'h00
`define RDATA_RESET           8'h00
`define RDATA_UNMAPPED        8'h00
`define STATUS_PIN_RESET      1'b0

`endif

//--- hdl/refctl_pkg.sv
package refctl_pkg;
    typedef logic [7:0] reg_byte_t;
    typedef logic [9:0] reg_addr_t;
endpackage : refctl_pkg

//--- hdl/pll_status_if.sv
`timescale 1ns/100ps
`default_nettype none

interface pll_status_if;
    logic                 freeze;
    refctl_pkg::reg_byte_t live;
    refctl_pkg::reg_byte_t held;

    modport ctrl (output freeze, output live, input held);
    modport hold (input freeze, input live, output held);
endinterface : pll_status_if

`default_nettype wire

//--- hdl/pll_status_hold.sv
`timescale 1ns/100ps
`default_nettype none
`include "refctl_params.svh"

module pll_status_hold (
    input  wire logic     mclk,
    input  wire logic     sys_rst,
    pll_status_if.hold    stat
);
    refctl_pkg::reg_byte_t held;
    refctl_pkg::reg_byte_t next_held;

    // ------------------------------------------------------------
    // Readback image: follows the live status unless frozen.
    // ------------------------------------------------------------
    always_comb begin
        next_held = held;
        if (!stat.freeze) begin
            next_held = stat.live;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            held <= `PLL_STATUS_RESET;
        end else begin
            held <= next_held;
        end
    end

    assign stat.held = held;
endmodule : pll_status_hold

`default_nettype wire

//--- hdl/reference_input_control_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "refctl_params.svh"

module reference_input_control_regs #(
    parameter int REG_WIDTH  = 8,
    parameter int ADDR_WIDTH = 10
) (
    input  wire logic                  mclk,
    input  wire logic                  sys_rst,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    input  wire refctl_pkg::reg_addr_t reg_addr,
    input  wire refctl_pkg::reg_byte_t reg_wdata,
    output var  refctl_pkg::reg_byte_t reg_rdata,
    input  wire logic                  status_eeprom,
    input  wire logic                  status_selected,
    input  wire refctl_pkg::reg_byte_t pll_status_live,
    output var  logic                  second_reference_input_pwr,
    output var  logic                  first_reference_input_pwr,
    output var  logic                  differential_mode,
    output var  logic                  crystal_oscillator_amp_en,
    output var  logic                  doubler_en,
    output var  logic                  status_pin,
    output var  refctl_pkg::reg_byte_t pll_status_readback
);
    refctl_pkg::reg_byte_t ref_cfg;
    refctl_pkg::reg_byte_t next_ref_cfg;
    refctl_pkg::reg_byte_t ref_misc;
    refctl_pkg::reg_byte_t next_ref_misc;
    refctl_pkg::reg_byte_t next_reg_rdata;
    logic                  next_status_pin;
    refctl_pkg::reg_byte_t cfg_mask;
    refctl_pkg::reg_byte_t misc_mask;
    logic                  next_second_reference_input_pwr;
    logic                  next_first_reference_input_pwr;
    logic                  next_differential_mode;
    logic                  next_crystal_oscillator_amp_en;
    logic                  next_doubler_en;
    logic                  cfg_write;
    logic                  misc_write;
    logic                  eeprom_at_pin;
    logic                  readback_freeze;

    // Reset images, read bit by bit for the output flip-flops.
    localparam refctl_pkg::reg_byte_t CFG_RESET  = `REF_CFG_RESET;
    localparam refctl_pkg::reg_byte_t MISC_RESET = `REF_MISC_RESET;

    pll_status_if stat ();

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // The port types fix both widths, so no other value can be served.
    if (REG_WIDTH != $bits(refctl_pkg::reg_byte_t)) begin : g_reg_width_check
        $error("REG_WIDTH must equal the register byte width");
    end
    if (ADDR_WIDTH != $bits(refctl_pkg::reg_addr_t)) begin : g_addr_width_check
        $error("ADDR_WIDTH must equal the register address width");
    end
    if (`REF_CFG_SECOND_REFERENCE_INPUT_BIT >= REG_WIDTH) begin : g_cfg_field_check
        $error("Every config field must lie inside the register");
    end
    if (`REF_MISC_EEPROM_BIT >= REG_WIDTH) begin : g_misc_field_check
        $error("Every misc field must lie inside the register");
    end
    if (`REF_CFG_OFFSET == `REF_MISC_OFFSET) begin : g_offset_check
        $error("The two register offsets must differ");
    end

    // ------------------------------------------------------------
    // Address decode and field views
    // ------------------------------------------------------------
    always_comb begin
        cfg_write       = reg_wr && (reg_addr == `REF_CFG_OFFSET);
        misc_write      = reg_wr && (reg_addr == `REF_MISC_OFFSET);
        eeprom_at_pin   = ref_misc[`REF_MISC_EEPROM_BIT];
        readback_freeze = ref_misc[`REF_MISC_FREEZE_BIT];
    end

    // ------------------------------------------------------------
    // Implemented bits; all others store nothing and read zero.
    // ------------------------------------------------------------
    always_comb begin
        cfg_mask  = 8'h00;
        misc_mask = 8'h00;
        cfg_mask[`REF_CFG_DIFF_BIT]      = 1'b1;
        cfg_mask[`REF_CFG_FIRST_REFERENCE_INPUT_BIT]      = 1'b1;
        cfg_mask[`REF_CFG_SECOND_REFERENCE_INPUT_BIT]      = 1'b1;
        misc_mask[`REF_MISC_FREEZE_BIT]  = 1'b1;
        misc_mask[`REF_MISC_DOUBLER_BIT] = 1'b1;
        misc_mask[`REF_MISC_XTAL_BIT]    = 1'b1;
        misc_mask[`REF_MISC_EEPROM_BIT]  = 1'b1;
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    // The power bits are stored as written even in differential mode;
    // keeping them clear there is left to software.
    always_comb begin
        next_ref_cfg  = ref_cfg;
        next_ref_misc = ref_misc;
        if (cfg_write) begin
            // Reserved bits are masked so they never hold a value.
            next_ref_cfg = reg_wdata & cfg_mask;
        end
        if (misc_write) begin
            next_ref_misc = reg_wdata & misc_mask;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ref_cfg  <= `REF_CFG_RESET;
            ref_misc <= `REF_MISC_RESET;
        end else begin
            ref_cfg  <= next_ref_cfg;
            ref_misc <= next_ref_misc;
        end
    end

    // ------------------------------------------------------------
    // Read data, held until the next read strobe
    // ------------------------------------------------------------
    // A read and a write in one cycle return the value before the write.
    always_comb begin
        next_reg_rdata = reg_rdata;
        if (reg_rd) begin
            case (reg_addr)
                `REF_CFG_OFFSET:    next_reg_rdata = ref_cfg;
                `REF_MISC_OFFSET:   next_reg_rdata = ref_misc;
                `PLL_STATUS_OFFSET: next_reg_rdata = stat.held;
                default:            next_reg_rdata = `RDATA_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            reg_rdata <= `RDATA_RESET;
        end else begin
            reg_rdata <= next_reg_rdata;
        end
    end

    // ------------------------------------------------------------
    // Status pin source
    // ------------------------------------------------------------
    // The pin shows its source one cycle late, as every output is registered.
    always_comb begin
        if (eeprom_at_pin) begin
            next_status_pin = status_eeprom;
        end else begin
            next_status_pin = status_selected;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            status_pin <= `STATUS_PIN_RESET;
        end else begin
            status_pin <= next_status_pin;
        end
    end

    // ------------------------------------------------------------
    // Control outputs, loaded on the same edge as the stored bits
    // ------------------------------------------------------------
    // Each output has its own flip-flop so no decode sits behind a pin.
    always_comb begin
        next_second_reference_input_pwr = next_ref_cfg[`REF_CFG_SECOND_REFERENCE_INPUT_BIT];
        next_first_reference_input_pwr  = next_ref_cfg[`REF_CFG_FIRST_REFERENCE_INPUT_BIT];
        next_differential_mode          = next_ref_cfg[`REF_CFG_DIFF_BIT];
        next_crystal_oscillator_amp_en  = next_ref_misc[`REF_MISC_XTAL_BIT];
        next_doubler_en                 = next_ref_misc[`REF_MISC_DOUBLER_BIT];
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            second_reference_input_pwr <= CFG_RESET[`REF_CFG_SECOND_REFERENCE_INPUT_BIT];
            first_reference_input_pwr  <= CFG_RESET[`REF_CFG_FIRST_REFERENCE_INPUT_BIT];
            differential_mode          <= CFG_RESET[`REF_CFG_DIFF_BIT];
            crystal_oscillator_amp_en  <= MISC_RESET[`REF_MISC_XTAL_BIT];
            doubler_en                 <= MISC_RESET[`REF_MISC_DOUBLER_BIT];
        end else begin
            second_reference_input_pwr <= next_second_reference_input_pwr;
            first_reference_input_pwr  <= next_first_reference_input_pwr;
            differential_mode          <= next_differential_mode;
            crystal_oscillator_amp_en  <= next_crystal_oscillator_amp_en;
            doubler_en                 <= next_doubler_en;
        end
    end

    // ------------------------------------------------------------
    // PLL status readback image
    // ------------------------------------------------------------
    // Freezing acts from the cycle after the write; the image keeps its last value.
    always_comb begin
        stat.freeze         = readback_freeze;
        stat.live           = pll_status_live;
        pll_status_readback = stat.held;
    end

    pll_status_hold u_hold (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .stat    (stat.hold)
    );
endmodule : reference_input_control_regs

`default_nettype wire

//--- sim/refctl_sva.sv
`timescale 1ns/100ps
`default_nettype none
module refctl_sva (
    input wire logic                  mclk,
    input wire logic                  sys_rst,
    input wire logic                  reg_wr,
    input wire logic                  reg_rd,
    input wire refctl_pkg::reg_addr_t reg_addr,
    input wire refctl_pkg::reg_byte_t reg_wdata,
    input wire refctl_pkg::reg_byte_t reg_rdata,
    input wire logic                  status_eeprom,
    input wire logic                  status_selected,
    input wire refctl_pkg::reg_byte_t pll_status_live,
    input wire logic                  second_reference_input_pwr,
    input wire logic                  first_reference_input_pwr,
    input wire logic                  differential_mode,
    input wire logic                  crystal_oscillator_amp_en,
    input wire logic                  doubler_en,
    input wire logic                  status_pin,
    input wire refctl_pkg::reg_byte_t pll_status_readback
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    wire logic wc = reg_wr && reg_addr == 10'h01c;
    wire logic wm = reg_wr && reg_addr == 10'h01d;
    property p_r1; wc |=> second_reference_input_pwr == $past(reg_wdata[2]); endproperty
    a_r1: assert property (p_r1) else $error("second input power wrong");
    property p_r2; wc |=> first_reference_input_pwr == $past(reg_wdata[1]); endproperty
    a_r2: assert property (p_r2) else $error("first input power wrong");
    property p_r3; wc |=> differential_mode == $past(reg_wdata[0]); endproperty
    a_r3: assert property (p_r3) else $error("reference mode wrong");
    property p_r5;
        wm ##1 !wm |=> status_pin ==
            ($past(reg_wdata[7], 2) ? $past(status_eeprom) : $past(status_selected));
    endproperty
    a_r5: assert property (p_r5) else $error("status pin source wrong");
    property p_r6; wm |=> crystal_oscillator_amp_en == $past(reg_wdata[6]); endproperty
    a_r6: assert property (p_r6) else $error("amplifier enable wrong");
    property p_r7; wm |=> doubler_en == $past(reg_wdata[5]); endproperty
    a_r7: assert property (p_r7) else $error("doubler enable wrong");
    property p_r8;
        wm ##1 (!wm)[*3] |=> ($past(reg_wdata[4], 4) ? $stable(pll_status_readback)
            : pll_status_readback == $past(pll_status_live));
    endproperty
    a_r8: assert property (p_r8) else $error("status readback update wrong");
    property p_r9;
        reg_rd && reg_addr == 10'h01c |=> reg_rdata == {5'h00, $past(second_reference_input_pwr),
            $past(first_reference_input_pwr), $past(differential_mode)};
    endproperty
    a_r9: assert property (p_r9) else $error("config readback wrong");
    cover property (wc && reg_wdata[0]);
    cover property (wm && reg_wdata[4]);
    cover property (reg_rd && reg_addr == 10'h01f);
endmodule : refctl_sva
bind reference_input_control_regs refctl_sva u_refctl_sva (.*);
`default_nettype wire

//--- sim/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
module testbench;
    logic mclk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, status_eeprom = 0, status_selected = 0;
    refctl_pkg::reg_addr_t reg_addr = 10'h000;
    refctl_pkg::reg_byte_t reg_wdata = 8'h00, pll_status_live = 8'h00;
    refctl_pkg::reg_byte_t reg_rdata, pll_status_readback;
    logic second_reference_input_pwr, first_reference_input_pwr, differential_mode;
    logic crystal_oscillator_amp_en, doubler_en, status_pin;
    int bad_count = 0, checks = 0;
    wire logic [4:0] outs = {second_reference_input_pwr, first_reference_input_pwr,
        differential_mode, crystal_oscillator_amp_en, doubler_en};
    reference_input_control_regs u_reference_input_control_regs (.*);
    always #12.5 mclk = ~mclk;
    task automatic complete_run;
        if (bad_count == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    task automatic wr(input refctl_pkg::reg_addr_t a, input refctl_pkg::reg_byte_t d);
        @(negedge mclk);
        reg_wr = 1; reg_addr = a; reg_wdata = d;
        @(negedge mclk);
        reg_wr = 0;
    endtask : wr
    task automatic rd(input refctl_pkg::reg_addr_t a, input refctl_pkg::reg_byte_t e);
        @(negedge mclk);
        reg_rd = 1; reg_addr = a;
        @(negedge mclk);
        reg_rd = 0;
        `CHK("reg_rdata", e, reg_rdata)
    endtask : rd
    task automatic pin(input logic eep, input logic sel, input logic e);
        status_eeprom = eep; status_selected = sel;
        repeat (2) @(negedge mclk);
        `CHK("status_pin", e, status_pin)
    endtask : pin
    task automatic t_reset;
        `CHK("outs", 5'h00, outs)
        rd(10'h01c, 8'h00);
        rd(10'h01d, 8'h80);
        rd(10'h3ff, 8'h00);
        pin(1'b1, 1'b0, 1'b1);
    endtask : t_reset
    task automatic t_cfg;
        for (int i = 0; i < 8; i++) begin
            if (i[0] && i[2:1] != 2'h0) continue;
            wr(10'h01c, 8'hf8 | 8'(i));
            `CHK("outs", {3'(i), 2'h0}, outs)
            rd(10'h01c, 8'(i));
        end
    endtask : t_cfg
    task automatic t_misc;
        wr(10'h01d, 8'h6f);
        `CHK("outs", 5'h1b, outs)
        rd(10'h01d, 8'h60);
        pin(1'b1, 1'b0, 1'b0);
        pin(1'b0, 1'b1, 1'b1);
        wr(10'h01d, 8'h80);
        `CHK("outs", 5'h18, outs)
        pin(1'b1, 1'b0, 1'b1);
        pin(1'b0, 1'b1, 1'b0);
    endtask : t_misc
    task automatic t_freeze;
        pll_status_live = 8'h3c;
        wr(10'h01d, 8'h10);
        repeat (2) @(negedge mclk);
        pll_status_live = 8'ha5;
        repeat (3) @(negedge mclk);
        `CHK("readback", 8'h3c, pll_status_readback)
        rd(10'h01f, 8'h3c);
        wr(10'h01d, 8'h00);
        repeat (3) @(negedge mclk);
        `CHK("readback", 8'ha5, pll_status_readback)
    endtask : t_freeze
    task automatic t_mid_reset;
        wr(10'h01c, 8'h06);
        wr(10'h01d, 8'h70);
        sys_rst = 1;
        repeat (2) @(negedge mclk);
        sys_rst = 0;
        `CHK("outs", 5'h00, outs)
        `CHK("readback", 8'h00, pll_status_readback)
        `CHK("reg_rdata", 8'h00, reg_rdata)
        `CHK("status_pin", 1'b0, status_pin)
        rd(10'h01d, 8'h80);
        rd(10'h01c, 8'h00);
    endtask : t_mid_reset
    initial begin
        repeat (10) @(negedge mclk);
        sys_rst = 0;
        t_reset;
        t_cfg;
        t_misc;
        t_freeze;
        t_mid_reset;
        complete_run;
    end
    initial begin
        #20000;
        bad_count++;
        complete_run;
    end
endmodule : testbench
`default_nettype wire
